// file: include/csb_defs.svh
// Constants for the clock synchronizer boot configuration sequencer
`ifndef CSB_DEFS_SVH
`define CSB_DEFS_SVH
`define CSB_NUM_PAGES      9
`define CSB_LOW_POWER_PAGE 4'h3
`define CSB_OFFSET_RESET   4'h0
`define CSB_OVERLAY_RESET  1'b0
`define CSB_LVL_L          2'h0
`define CSB_LVL_M          2'h1
`define CSB_LVL_H          2'h2
`define CSB_IFACE_TWO_WIRE 1'b0
`define CSB_ROM_WORDS      16
`define CSB_EE_WORDS       8
`define CSB_SETTLE_NS      200
`define CSB_CLK_NS         20
`define CSB_SETTLE_CYC     ((`CSB_SETTLE_NS + `CSB_CLK_NS - 1) / `CSB_CLK_NS)
`define CSB_LOCK_BLANK_CYC 4'h4
`endif

// file: include/csb_pkg.sv
// Types for the boot configuration sequencer
package csb_pkg;
   typedef enum logic [7:0] {
      CSB_ST_POWERED_DOWN = 8'h01,
      CSB_ST_SETTLE       = 8'h02,
      CSB_ST_STRAPS       = 8'h04,
      CSB_ST_ROM_LOAD     = 8'h08,
      CSB_ST_OVERLAY      = 8'h10,
      CSB_ST_CALIBRATE    = 8'h20,
      CSB_ST_WAIT_LOCK    = 8'h40,
      CSB_ST_RUN          = 8'h80
   } csb_state_e;
   typedef logic [1:0] csb_level_t;
   typedef logic [3:0] csb_page_t;
endpackage

// file: logic/csb_rom.sv
// Mask ROM of configuration pages with registered read data
`timescale 1ns/10ps
`default_nettype none
module csb_rom #(
   parameter int WIDTH = 32,
   parameter int PAGES = 9,
   parameter int WORDS = 16
) (
   input  wire logic                             clk_sys_i, // System clock
   input  wire logic                             clk_en_i,  // Clock enable
   input  wire logic [$clog2(PAGES*WORDS)-1:0]   addr_i,    // Flat word address
   output logic      [WIDTH-1:0]                 data_o     // Registered word
);
   localparam int DEPTH = PAGES * WORDS;
   logic [WIDTH-1:0] rom_mem [DEPTH];

   // Contents fixed at build time; there is no write port at all
   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_fill
         assign rom_mem[i] = WIDTH'(i * 32'h9e3779b1);
      end
   endgenerate

   // Registered read
   always_ff @(posedge clk_sys_i) begin
      if (clk_en_i) begin
         data_o <= rom_mem[addr_i];
      end
   end
endmodule
`default_nettype wire

// file: logic/csb_boot_config.sv
// Power-on and restart configuration sequencer for the clock synchronizer
`timescale 1ns/10ps
`default_nettype none
`include "csb_defs.svh"
module csb_boot_config #(
   parameter int NUM_LOOPS = 3,                 // Analog loops
   parameter int WIDTH     = 32,                // Config word width
   parameter int ROM_WORDS = `CSB_ROM_WORDS,    // Words per ROM page
   parameter int EE_WORDS  = `CSB_EE_WORDS      // Overlay words (first part of page)
) (
   input  wire logic                  clk_sys_i,              // 50 MHz clock
   input  wire logic                  reset_i,                // Sync reset, high
   input  wire logic                  clk_en_i,               // Freezes state when low
   input  wire logic                  power_down_n_i,         // Power-down pin, low active
   input  wire logic                  iface_select_strap_i,   // Interface strap pin
   input  wire csb_pkg::csb_level_t   page_strap_high_i,      // Three-level page strap
   input  wire csb_pkg::csb_level_t   page_strap_low_i,       // Three-level page strap
   input  wire logic [3:0]            stored_page_offset_i,   // From EEPROM
   input  wire logic                  overlay_enable_i,       // From EEPROM
   input  wire logic [WIDTH-1:0]      ee_data_i,              // EEPROM overlay word
   input  wire logic                  global_soft_restart_i,  // Restart pulse
   input  wire logic [NUM_LOOPS-1:0]  analog_loop_soft_restart_i, // Per-loop pulses
   input  wire logic [NUM_LOOPS-1:0]  loop_locked_i,          // Loop lock pins
   input  wire logic                  digital_cfg_valid_i,    // Digital loop cfg usable
   output logic [$clog2(EE_WORDS)-1:0] ee_addr_o,             // EEPROM word address
   output logic [$clog2(ROM_WORDS)-1:0] cfg_addr_o,           // Active register index
   output logic [WIDTH-1:0]           cfg_data_o,             // Active register word
   output logic                       cfg_we_o,               // Write strobe
   output logic                       spi_selected_o,         // 1 SPI, 0 two-wire
   output logic                       addr_pin_is_select_o,   // Shared pin is CS
   output csb_pkg::csb_page_t         rom_page_o,             // Selected page
   output logic                       low_power_o,            // Page three chosen
   output logic [NUM_LOOPS-1:0]       loop_cal_o,             // Calibrate per loop
   output logic [NUM_LOOPS-1:0]       loop_outputs_hold_o,    // Outputs disrupted
   output logic                       lock_to_crystal_o,      // Lock to crystal_osc_input
   output logic                       divider_align_o,        // Realign dividers pulse
   output logic                       config_done_o           // Host may program
);
   import csb_pkg::*;

   localparam int PAGES   = `CSB_NUM_PAGES;
   localparam int AW      = $clog2(PAGES * ROM_WORDS);
   localparam int WW      = $clog2(ROM_WORDS);
   localparam int SETTLE  = `CSB_SETTLE_CYC;

   // Map one strap pair to its page, zero offset
   function automatic csb_page_t strap_page(input csb_level_t hi, input csb_level_t lo);
      csb_page_t p;
      p = 4'h0;
      unique case ({hi, lo})
         {`CSB_LVL_L, `CSB_LVL_L}: p = 4'h0;
         {`CSB_LVL_L, `CSB_LVL_H}: p = 4'h1;
         {`CSB_LVL_H, `CSB_LVL_L}: p = 4'h2;
         {`CSB_LVL_H, `CSB_LVL_H}: p = 4'h3;
         {`CSB_LVL_L, `CSB_LVL_M}: p = 4'h4;
         {`CSB_LVL_M, `CSB_LVL_L}: p = 4'h5;
         {`CSB_LVL_M, `CSB_LVL_M}: p = 4'h6;
         {`CSB_LVL_M, `CSB_LVL_H}: p = 4'h7;
         {`CSB_LVL_H, `CSB_LVL_M}: p = 4'h8;
         default:                  p = 4'h0;
      endcase
      return p;
   endfunction

   // Two-flop synchronisers for all pins; first stage read only by second
   logic [12:0] pin_meta_reg;
   logic [12:0] pin_sync_reg;
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         pin_meta_reg <= 13'h0;
         pin_sync_reg <= 13'h0;
      end else if (clk_en_i) begin
         pin_meta_reg <= {power_down_n_i, iface_select_strap_i, page_strap_high_i,
                          page_strap_low_i, loop_locked_i[2:0], digital_cfg_valid_i,
                          overlay_enable_i, global_soft_restart_i, 1'b0};
         pin_sync_reg <= pin_meta_reg;
      end
   end
   logic pd_n_s, iface_s, ovl_s, dvalid_s, grst_s;
   csb_level_t ph_s, pl_s;
   logic [2:0] lock_s;
   assign pd_n_s   = pin_sync_reg[12];
   assign iface_s  = pin_sync_reg[11];
   assign ph_s     = pin_sync_reg[10:9];
   assign pl_s     = pin_sync_reg[8:7];
   assign lock_s   = pin_sync_reg[6:4];
   assign dvalid_s = pin_sync_reg[3];
   assign ovl_s    = pin_sync_reg[2];
   assign grst_s   = pin_sync_reg[1];

   // Page offset from the nonvolatile store; reads as factory zero until first loaded
   logic [3:0] offset_reg;
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         offset_reg <= `CSB_OFFSET_RESET;
      end else if (clk_en_i) begin
         offset_reg <= stored_page_offset_i;
      end
   end

   // Per-loop restart pins, synchronised as a vector
   logic [NUM_LOOPS-1:0] lrst_meta_reg;
   logic [NUM_LOOPS-1:0] lrst_sync_reg;
   logic [NUM_LOOPS-1:0] lrst_prev_reg;
   logic                 grst_prev_reg;
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         lrst_meta_reg <= '0;
         lrst_sync_reg <= '0;
         lrst_prev_reg <= '0;
         grst_prev_reg <= 1'b0;
      end else if (clk_en_i) begin
         lrst_meta_reg <= analog_loop_soft_restart_i;
         lrst_sync_reg <= lrst_meta_reg;
         lrst_prev_reg <= lrst_sync_reg;
         grst_prev_reg <= grst_s;
      end
   end
   logic                 grst_rise;
   logic [NUM_LOOPS-1:0] lrst_rise;
   assign grst_rise = grst_s & ~grst_prev_reg;
   assign lrst_rise = lrst_sync_reg & ~lrst_prev_reg;

   // Sequencer state
   csb_state_e state_reg;
   logic [7:0] settle_cnt_reg;
   logic [WW-1:0] word_reg;
   logic       overlay_on_reg;
   logic       rom_valid_reg;
   logic       ovl_valid_reg;
   logic [WW-1:0] addr_pipe_reg;

   logic       word_last;
   assign word_last = (word_reg == WW'(ROM_WORDS - 1));

   // ROM read data registered inside the memory
   logic [WIDTH-1:0] rom_data;
   logic [AW-1:0]    rom_addr;
   assign rom_addr = AW'(rom_page_o * ROM_WORDS) + AW'(word_reg);
   csb_rom #(
      .WIDTH (WIDTH),
      .PAGES (PAGES),
      .WORDS (ROM_WORDS)
   ) u_rom (
      .clk_sys_i (clk_sys_i),
      .clk_en_i  (clk_en_i),
      .addr_i    (rom_addr),
      .data_o    (rom_data)
   );

   // Main boot and restart sequence
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_reg      <= CSB_ST_POWERED_DOWN;
         settle_cnt_reg <= 8'h0;
         word_reg       <= '0;
      end else if (clk_en_i) begin
         if (!pd_n_s) begin
            state_reg <= CSB_ST_POWERED_DOWN; // Held off while pin is low
         end else begin
            unique case (state_reg)
               CSB_ST_POWERED_DOWN: begin
                  state_reg      <= CSB_ST_SETTLE;
                  settle_cnt_reg <= 8'h0;
               end
               CSB_ST_SETTLE: begin
                  // Let strap levels settle before they are trusted
                  if (settle_cnt_reg == 8'(SETTLE - 1)) begin
                     state_reg <= CSB_ST_STRAPS;
                  end else begin
                     settle_cnt_reg <= settle_cnt_reg + 8'h1;
                  end
               end
               CSB_ST_STRAPS: begin
                  state_reg <= CSB_ST_ROM_LOAD;
                  word_reg  <= '0;
               end
               CSB_ST_ROM_LOAD: begin
                  if (word_last) begin
                     word_reg  <= '0;
                     state_reg <= overlay_on_reg ? CSB_ST_OVERLAY
                                                 : CSB_ST_CALIBRATE;
                  end else begin
                     word_reg <= word_reg + WW'(1);
                  end
               end
               CSB_ST_OVERLAY: begin
                  if (word_reg == WW'(EE_WORDS - 1)) begin
                     state_reg <= CSB_ST_CALIBRATE;
                  end else begin
                     word_reg <= word_reg + WW'(1);
                  end
               end
               CSB_ST_CALIBRATE: begin
                  state_reg <= CSB_ST_WAIT_LOCK;
               end
               CSB_ST_WAIT_LOCK: begin
                  // Holds drop only on a fresh lock, so outside low power this waits for every loop
                  if (low_power_o || (loop_outputs_hold_o == '0)) begin
                     state_reg <= CSB_ST_RUN;
                  end
               end
               CSB_ST_RUN: begin
                  if (grst_rise) begin
                     state_reg <= CSB_ST_STRAPS;
                  end
               end
            endcase
         end
      end
   end

   // Straps captured once per power-on; a soft restart keeps them
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         spi_selected_o       <= 1'b0;
         addr_pin_is_select_o <= 1'b0;
         rom_page_o           <= 4'h0;
         low_power_o          <= 1'b0;
         overlay_on_reg       <= `CSB_OVERLAY_RESET;
      end else if (clk_en_i && state_reg == CSB_ST_SETTLE
                   && settle_cnt_reg == 8'(SETTLE - 1)) begin
         spi_selected_o       <= (iface_s != `CSB_IFACE_TWO_WIRE);
         addr_pin_is_select_o <= (iface_s != `CSB_IFACE_TWO_WIRE);
         rom_page_o  <= strap_page(ph_s, pl_s) + offset_reg;
         low_power_o <= (csb_page_t'(strap_page(ph_s, pl_s) + offset_reg)
                         == `CSB_LOW_POWER_PAGE);
         overlay_on_reg <= ovl_s;
      end
   end

   // Read pipeline: data arrives one cycle after its address
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         rom_valid_reg <= 1'b0;
         ovl_valid_reg <= 1'b0;
         addr_pipe_reg <= '0;
         cfg_addr_o    <= '0;
      end else if (clk_en_i) begin
         rom_valid_reg <= (state_reg == CSB_ST_ROM_LOAD);
         ovl_valid_reg <= (state_reg == CSB_ST_OVERLAY);
         // Index follows its data through the same two stages
         addr_pipe_reg <= word_reg;
         cfg_addr_o    <= addr_pipe_reg;
      end
   end

   // Writes into the active registers; ROM itself is never written
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         cfg_we_o   <= 1'b0;
         cfg_data_o <= '0;
         ee_addr_o  <= '0;
      end else if (clk_en_i) begin
         ee_addr_o <= word_reg[$clog2(EE_WORDS)-1:0];
         cfg_we_o  <= rom_valid_reg | ovl_valid_reg;
         cfg_data_o <= ovl_valid_reg ? ee_data_i : rom_data;
      end
   end

   // Per-loop calibration and output holds
   generate
      for (genvar i = 0; i < NUM_LOOPS; i++) begin : g_loop
         logic       cal_now;
         logic [3:0] blank_reg;
         // Outside low power, calibrate on every sequence start, or on this loop's own restart only
         assign cal_now = (state_reg == CSB_ST_CALIBRATE && !low_power_o)
                          || (state_reg == CSB_ST_RUN && lrst_rise[i] && !low_power_o);
         always_ff @(posedge clk_sys_i) begin
            if (reset_i) begin
               loop_cal_o[i]          <= 1'b0;
               loop_outputs_hold_o[i] <= 1'b1;
               blank_reg              <= 4'h0;
            end else if (clk_en_i) begin
               loop_cal_o[i] <= cal_now;
               // Lock seen right after a calibration is stale; a loop must drop it by then
               if (cal_now) begin
                  blank_reg <= `CSB_LOCK_BLANK_CYC;
               end else if (blank_reg != 4'h0) begin
                  blank_reg <= blank_reg - 4'h1;
               end
               if (state_reg != CSB_ST_RUN && state_reg != CSB_ST_WAIT_LOCK) begin
                  loop_outputs_hold_o[i] <= 1'b1;
               end else if (state_reg == CSB_ST_RUN && lrst_rise[i]) begin
                  loop_outputs_hold_o[i] <= 1'b1;
               end else if (low_power_o) begin
                  loop_outputs_hold_o[i] <= 1'b1;
               end else if (lock_s[i] && blank_reg == 4'h0) begin
                  loop_outputs_hold_o[i] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Status outputs
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         lock_to_crystal_o <= 1'b1;
         divider_align_o   <= 1'b0;
         config_done_o     <= 1'b0;
      end else if (clk_en_i) begin
         lock_to_crystal_o <= !dvalid_s;
         divider_align_o   <= (state_reg == CSB_ST_CALIBRATE);
         config_done_o     <= (state_reg == CSB_ST_RUN);
      end
   end
endmodule
`default_nettype wire

// file: test/csb_boot_config_chk.sv
// Port-level assertions for the boot configuration sequencer
`timescale 1ns/10ps
`default_nettype none
module csb_boot_config_chk #(
   parameter int NUM_LOOPS = 3                           // Analog loops
) (
   input  wire logic                 clk_sys_i,             // Clock
   input  wire logic                 reset_i,               // Sync reset
   input  wire logic                 power_down_n_i,        // Power-down pin
   input  wire logic                 global_soft_restart_i, // Global restart
   input  wire logic [NUM_LOOPS-1:0] analog_loop_soft_restart_i, // Loop restarts
   input  wire logic                 cfg_we_o,              // Write strobe
   input  wire logic                 spi_selected_o,        // Interface choice
   input  wire logic                 addr_pin_is_select_o,  // Shared pin role
   input  wire csb_pkg::csb_page_t   rom_page_o,            // Page
   input  wire logic                 low_power_o,           // Low power
   input  wire logic [NUM_LOOPS-1:0] loop_cal_o,            // Calibrate pulses
   input  wire logic [NUM_LOOPS-1:0] loop_outputs_hold_o,   // Outputs disrupted
   input  wire logic                 divider_align_o,       // Align pulse
   input  wire logic                 config_done_o          // Done
);
   // One clock domain, so clocking and reset are given once
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);

   pd_drop_a: assert property (!power_down_n_i [*5] |-> !config_done_o)
      else $error("done stays up while powered down");
   pair_sel_a: assert property (spi_selected_o == addr_pin_is_select_o)
      else $error("shared pin role disagrees with interface");
   low_page_a: assert property (config_done_o |-> low_power_o == (rom_page_o == 4'h3))
      else $error("low power flag does not match page");
   low_quiet_a: assert property (low_power_o |-> loop_cal_o == '0 && &loop_outputs_hold_o)
      else $error("loop active in low power");
   sel_stable_a: assert property (config_done_o && $past(config_done_o) |->
      $stable(rom_page_o) && $stable(spi_selected_o))
      else $error("selection moved after capture");
   no_write_a: assert property (config_done_o |-> !cfg_we_o)
      else $error("configuration write after start-up");
   done_lock_a: assert property ($rose(config_done_o) && !low_power_o |->
      loop_outputs_hold_o == '0)
      else $error("done before every loop locked");
   one_loop_a: assert property ($rose(analog_loop_soft_restart_i[1]) && config_done_o &&
      !global_soft_restart_i |-> ##[1:8] loop_cal_o == 3'h2)
      else $error("loop restart did not calibrate only its loop");
   cal_pulse_a: assert property (loop_cal_o != '0 |=> loop_cal_o == '0)
      else $error("calibrate pulse longer than a cycle");
   align_a: assert property ($rose(global_soft_restart_i) && config_done_o |->
      ##[1:200] divider_align_o)
      else $error("no divider alignment after global restart");
endmodule
bind csb_boot_config csb_boot_config_chk #(.NUM_LOOPS(NUM_LOOPS)) chk_u (.clk_sys_i, .reset_i,
   .power_down_n_i, .global_soft_restart_i, .analog_loop_soft_restart_i, .cfg_we_o,
   .spi_selected_o, .addr_pin_is_select_o, .rom_page_o, .low_power_o, .loop_cal_o,
   .loop_outputs_hold_o, .divider_align_o, .config_done_o);
`default_nettype wire

// file: test/csb_loop_model.sv
// Far-side model: overlay memory words and analog loops that lock after calibration
`timescale 1ns/10ps
`default_nettype none
module csb_loop_model #(
   parameter int LOCK_BASE = 5                 // Lock time of loop 0, later loops slower
) (
   input  wire logic        clk_sys_i,       // Clock
   input  wire logic        power_down_n_i,  // Power-down pin
   input  wire logic [2:0]  loop_cal_i,      // Calibrate pulses
   input  wire logic [2:0]  ee_addr_i,       // Overlay word address
   output logic      [31:0] ee_data_o,       // Overlay word
   output logic      [2:0]  loop_locked_o    // Lock indications
);
   int lock_cnt [3];
   // Distinct word per address so a wrong address shows up in the data
   assign ee_data_o = 32'hc0de_0000 + 32'(ee_addr_i);
   // A loop only locks after a calibration, never on its own
   always_ff @(posedge clk_sys_i) begin
      for (int k = 0; k < 3; k++) begin
         if (!power_down_n_i) begin
            lock_cnt[k] <= -1;
            loop_locked_o[k] <= 1'b0;
         end else if (loop_cal_i[k]) begin
            lock_cnt[k] <= LOCK_BASE + 7 * k;
            loop_locked_o[k] <= 1'b0;
         end else if (lock_cnt[k] > 0) begin
            lock_cnt[k] <= lock_cnt[k] - 1;
         end else if (lock_cnt[k] == 0) begin
            loop_locked_o[k] <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: test/tb_csb_boot_config.sv
// Self-checking bench for the boot configuration sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_csb_boot_config;
   import csb_pkg::*;
   localparam logic [3:0] PG [9] = '{4'h0, 4'h4, 4'h1, 4'h5, 4'h6, 4'h7, 4'h2, 4'h8, 4'h3};
   logic        clk_sys_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        pd_n = 1'b0, iface = 1'b0, ov_en = 1'b0, dig_ok = 1'b1, g_rst = 1'b0;
   csb_level_t  st_hi = 2'h0, st_lo = 2'h0;
   logic [3:0]  offs = 4'h0;
   logic        clk_en = 1'b1;
   logic [3:0]  cfg_addr;
   logic [2:0]  l_rst = 3'h0, locked, cal, hold, ee_addr;
   logic [31:0] ee_data, cfg_data;
   logic        we, spi, sel, lp, ltc, align, done, done_q;
   csb_page_t   page;
   int          err_total = 0, total_checks = 0, seed = 32'h75c0;
   logic [16:0] exp_q [$];
   logic [16:0] last_exp;
   logic [5:0]  we_cnt;
   logic [2:0]  cal_cnt;

   csb_boot_config dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_en_i(clk_en),
      .power_down_n_i(pd_n), .iface_select_strap_i(iface), .page_strap_high_i(st_hi),
      .page_strap_low_i(st_lo), .stored_page_offset_i(offs), .overlay_enable_i(ov_en),
      .ee_data_i(ee_data), .global_soft_restart_i(g_rst), .analog_loop_soft_restart_i(l_rst),
      .loop_locked_i(locked), .digital_cfg_valid_i(dig_ok), .ee_addr_o(ee_addr),
      .cfg_addr_o(cfg_addr), .cfg_data_o(cfg_data), .cfg_we_o(we), .spi_selected_o(spi),
      .addr_pin_is_select_o(sel), .rom_page_o(page), .low_power_o(lp), .loop_cal_o(cal),
      .loop_outputs_hold_o(hold), .lock_to_crystal_o(ltc), .divider_align_o(align),
      .config_done_o(done));
   csb_loop_model far_u (.clk_sys_i(clk_sys_i), .power_down_n_i(pd_n), .loop_cal_i(cal),
      .ee_addr_i(ee_addr), .ee_data_o(ee_data), .loop_locked_o(locked));

   initial begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask

   // Bounded wait; a hang ends the run through the closing report
   task automatic wait_for(input logic lvl);
      int i;
      i = 0;
      while (done !== lvl && i < 600) begin
         cycles(1);
         i++;
      end
      if (i >= 600) begin
         check({16'h0, done}, {16'h0, lvl});
         test_done();
      end
   endtask

   // Power-on with given pins; note records page, interface, writes and calibrations
   task automatic power_on(input csb_level_t h, l, input logic ifc, ov, ok, input logic [3:0] o);
      logic [3:0] pg;
      pg = PG[h * 3 + l] + o;
      if (pg == 4'h3) ok = 1'b0;
      @(negedge clk_sys_i);
      pd_n = 1'b0;
      {st_hi, st_lo, iface, ov_en, dig_ok, offs} = {h, l, ifc, ov, ok, o};
      cycles(5);
      last_exp = {pg, ifc, ifc, pg == 4'h3, !ok, ov ? 6'h18 : 6'h10, pg == 4'h3 ? 3'h0 : 3'h3};
      exp_q.push_back(last_exp);
      pd_n = 1'b1;
      wait_for(1'b1);
      cycles(3);
   endtask

   // Global restart with strap pins moved; selection must not follow them
   task automatic global_restart(input logic [2:0] cal_exp);
      exp_q.push_back({last_exp[16:3], cal_exp});
      st_hi = csb_level_t'(2'h2 - st_hi);
      iface = !iface;
      offs = ~offs;
      g_rst = 1'b1;
      cycles(3);
      g_rst = 1'b0;
      wait_for(1'b0);
      wait_for(1'b1);
      cycles(3);
   endtask

   // Watcher: counts writes and calibrations, compares at each start-up completion
   always @(posedge clk_sys_i) begin
      #1;
      if (reset_i) begin
         {we_cnt, cal_cnt, done_q} = 10'h0;
      end else begin
         if (we) begin
            check({28'h0, cfg_addr}, {28'h0, we_cnt[3:0]});
            if (we_cnt[4]) check(cfg_data, 32'hc0de_0000 + 32'(we_cnt[2:0]));
         end
         we_cnt = we_cnt + 6'(we);
         cal_cnt = cal_cnt + 3'($countones(cal));
         if (done && !done_q) begin
            check({page, spi, sel, lp, ltc, we_cnt, cal_cnt}, exp_q.pop_front());
            {we_cnt, cal_cnt} = 9'h0;
         end
         done_q = done;
      end
   end

   initial begin
      repeat (4) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      reset_i = 1'b0;
      for (int p = 0; p < 9; p++) power_on(csb_level_t'(p / 3), csb_level_t'(p % 3),
         p[0], p[1], p != 8, 4'h0);
      $display("strap table test done");
      for (int r = 0; r < 6; r++) power_on(csb_level_t'($unsigned($random(seed)) % 3),
         csb_level_t'($unsigned($random(seed)) % 3), $random(seed), $random(seed),
         $random(seed), 4'($random(seed)));
      $display("random page test done");
      power_on(2'h1, 2'h1, 1'b1, 1'b1, 1'b1, 4'h0);
      l_rst = 3'h2;
      for (int c = 0; c < 40; c++) begin
         cycles(1);
         if (c == 3) l_rst = 3'h0;
         check({15'h0, hold[2], hold[0]}, 17'h0);
         if (c == 9 || c == 39) check({16'h0, hold[1]}, {16'h0, c == 9});
      end
      // Frozen clock enable: a restart pulse seen only while frozen must be lost
      clk_en = 1'b0;
      l_rst = 3'h1;
      cycles(4);
      l_rst = 3'h0;
      cycles(2);
      clk_en = 1'b1;
      for (int c = 0; c < 20; c++) begin
         cycles(1);
         check({28'h0, cal, hold[0]}, 32'h0);
      end
      global_restart(3'h4);
      $display("restart test done");
      pd_n = 1'b0;
      cycles(5);
      pd_n = 1'b1;
      cycles(30);
      reset_i = 1'b1;
      pd_n = 1'b0;
      cycles(2);
      reset_i = 1'b0;
      power_on(2'h0, 2'h2, 1'b0, 1'b1, 1'b1, 4'h1);
      $display("mid-load reset test done");
      test_done();
   end
endmodule
`default_nettype wire
